// ### hw/fcp_core.sv
// command/result phase interpreter of the floppy controller
// Operation
// - entering result phase after execution raises floppy interrupt output; sense entry does not.
// - no new command until all result bytes are read.
// - result phase shows request ready and direction both one.
// - after last result byte: ready one, direction zero, busy cleared.
// - invalid first byte interrupts; sense interrupt then reports invalid.
// - cylinder parameter accepted over full 0..255 range.
// - format writes the pattern byte into every data field.
// - perpendicular flag bit one marks that drive perpendicular.
// - relative seek direction bit zero steps out, one steps in.
// - size code zero uses 128 bytes, host gets short length.
// - short writes fill rest of physical sector with zeros.
// - crc spans the full physical sector.
// - count flag makes verify short length a sector count.
// - data queue enabled when active-low enable bit is zero.
// - implied seek enabled seeks before cylinder-bearing read/write.
// - command writes need ready one, direction zero; ready drops per byte. The core takes command and parameter phase writes even while ready is zero.
`timescale 1ns/1ps
`default_nettype none
module fcp_core (
   // clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RST,
   // host byte port
   input  wire logic                 WR_STB,
   input  wire logic [7:0]           WR_DATA,
   input  wire logic                 RD_STB,
   output logic      [7:0]           RD_DATA,
   // main status and interrupt
   output logic                      HOST_REQUEST_READY,
   output logic                      TRANSFER_TOWARD_HOST,
   output logic                      CONTROLLER_BUSY,
   output logic                      FLOPPY_IRQ,
   // execution side
   output logic                      EXEC_START,
   output logic [4:0]                EXEC_OPCODE,
   output fcp_pkg::fcp_params_t      EXEC_PARAMS,
   input  wire logic                 EXEC_DONE,
   input  wire logic [7:0]           EXEC_ST0,
   // decoded configuration and drive state
   output logic [3:0]                DRIVE_SELECT_ONEHOT,
   output logic [3:0]                PERPENDICULAR_DRIVE_FLAGS,
   output logic                      QUEUE_ENABLE,
   output logic                      IMPLIED_SEEK_ENABLE,
   output logic [14:0]               PHYS_BYTES,
   output logic [14:0]               HOST_BYTES,
   output logic [14:0]               ZERO_FILL,
   output logic [7:0]                SECTORS_PER_TRACK
);
   import fcp_pkg::*;

   typedef enum logic [PH_W-1:0] {
      PH_CMD    = 4'b0001,
      PH_PARAM  = 4'b0010,
      PH_EXEC   = 4'b0100,
      PH_RESULT = 4'b1000
   } fcp_phase_t;

   fcp_phase_t phase;
   fcp_phase_t next_phase;
   logic [4:0] opcode;
   logic [7:0] params [MAX_PARAMS];
   logic [3:0] param_idx;
   logic [3:0] param_need;
   logic [3:0] result_idx;
   logic [3:0] result_cnt;
   logic [7:0] results [MAX_RESULTS];
   logic       invalid_pending;
   logic       queue_en_n;
   logic       first_valid;
   logic       last_param;
   logic       last_result;
   logic [3:0] need_of;
   logic [7:0] param_view [MAX_PARAMS];

   // parameter counts per opcode; zero marks an invalid opcode
   always_comb begin
      case (WR_DATA[4:0])
         OP_READ, OP_WRITE, OP_VERIFY: need_of = 4'h8;
         OP_FORMAT:                    need_of = 4'h5;
         OP_SEEK, OP_CONFIGURE:        need_of = 4'h2;
         OP_PERP:                      need_of = 4'h1;
         OP_SENSE_INT:                 need_of = 4'hF;
         default:                      need_of = 4'h0;
      endcase
   end
   assign first_valid = (need_of != 4'h0);
   assign last_param  = (param_idx + 4'h1 == param_need);
   assign last_result = (result_idx + 4'h1 == result_cnt);

   // phase sequencing
   always_comb begin
      next_phase = phase;
      case (phase)
         PH_CMD: begin
            if (WR_STB && first_valid) begin
               if (need_of == 4'hF) next_phase = PH_RESULT; // sense has no params
               else next_phase = PH_PARAM;
            end
         end
         PH_PARAM:  if (WR_STB && last_param) next_phase = PH_EXEC;
         PH_EXEC:   if (EXEC_DONE) next_phase = PH_RESULT;
         PH_RESULT: if (RD_STB && last_result) next_phase = PH_CMD;
         default:   next_phase = PH_CMD;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (RST) phase <= PH_CMD;
      else phase <= next_phase;
   end

   // command capture; writes outside command phases are dropped
   always_ff @(posedge CLK) begin
      if (RST) begin
         opcode     <= 5'h00;
         param_idx  <= 4'h0;
         param_need <= 4'h0;
      end else if (WR_STB && phase == PH_CMD && first_valid) begin
         opcode     <= WR_DATA[4:0];
         param_idx  <= 4'h0;
         param_need <= need_of;
      end else if (WR_STB && phase == PH_PARAM) begin
         params[param_idx[2:0]] <= WR_DATA;
         param_idx              <= param_idx + 4'h1;
      end
   end

   // byte being written merged in, so the last parameter is seen at hand-off
   for (genvar g = 0; g < MAX_PARAMS; g++) begin : g_param_view
      assign param_view[g] = (param_idx[2:0] == 3'(g)) ? WR_DATA : params[g];
   end

   // invalid-command latch, consumed by the next sense interrupt
   always_ff @(posedge CLK) begin
      if (RST) invalid_pending <= 1'b0;
      else if (WR_STB && phase == PH_CMD && !first_valid) invalid_pending <= 1'b1;
      else if (WR_STB && phase == PH_CMD && need_of == 4'hF) invalid_pending <= 1'b0;
   end

   // result bytes loaded from execution or from sense
   always_ff @(posedge CLK) begin
      if (RST) begin
         result_idx <= 4'h0;
         result_cnt <= 4'h0;
      end else if (phase == PH_CMD && WR_STB && need_of == 4'hF) begin
         results[0] <= invalid_pending ? ST0_INVALID : ST0_NORMAL;
         result_idx <= 4'h0;
         result_cnt <= 4'h1;
      end else if (phase == PH_EXEC && EXEC_DONE) begin
         results[0] <= EXEC_ST0;
         results[1] <= params[1];
         result_idx <= 4'h0;
         result_cnt <= 4'h2;
      end else if (phase == PH_RESULT && RD_STB) begin
         result_idx <= result_idx + 4'h1;
      end
   end
   always_ff @(posedge CLK) begin
      if (RST) RD_DATA <= 8'h00;
      else if (phase == PH_CMD && WR_STB && need_of == 4'hF)
         RD_DATA <= invalid_pending ? ST0_INVALID : ST0_NORMAL;
      else if (phase == PH_EXEC && EXEC_DONE) RD_DATA <= EXEC_ST0;
      else if (phase == PH_RESULT && RD_STB) RD_DATA <= results[result_idx[2:0] + 3'h1];
   end

   // interrupt: result entry after execution or invalid first byte; reading a result clears it
   always_ff @(posedge CLK) begin
      if (RST) FLOPPY_IRQ <= 1'b0;
      else if (phase == PH_EXEC && EXEC_DONE) FLOPPY_IRQ <= 1'b1;
      else if (WR_STB && phase == PH_CMD && !first_valid) FLOPPY_IRQ <= 1'b1;
      else if (RD_STB && phase == PH_RESULT) FLOPPY_IRQ <= 1'b0;
      else if (WR_STB && phase == PH_CMD) FLOPPY_IRQ <= 1'b0;
   end

   // main status bits; ready drops one cycle after each byte write
   logic wr_seen;
   always_ff @(posedge CLK) begin
      if (RST) wr_seen <= 1'b0;
      else wr_seen <= WR_STB;
   end
   assign HOST_REQUEST_READY   = (phase == PH_CMD || phase == PH_PARAM ||
                                  phase == PH_RESULT) && !wr_seen;
   assign TRANSFER_TOWARD_HOST = (phase == PH_RESULT);
   assign CONTROLLER_BUSY      = (phase != PH_CMD);

   // configuration held across commands
   always_ff @(posedge CLK) begin
      if (RST) begin
         queue_en_n                <= CFG_QUEUE_EN_N_RST;
         IMPLIED_SEEK_ENABLE       <= 1'b0;
         PERPENDICULAR_DRIVE_FLAGS <= 4'h0;
      end else if (phase == PH_PARAM && WR_STB && last_param) begin
         if (opcode == OP_CONFIGURE) begin
            queue_en_n          <= WR_DATA[CFG_QUEUE_EN_N_BIT];
            IMPLIED_SEEK_ENABLE <= WR_DATA[CFG_IMPLIED_SEEK_BIT];
         end
         if (opcode == OP_PERP) PERPENDICULAR_DRIVE_FLAGS <= WR_DATA[3:0];
      end
   end
   assign QUEUE_ENABLE = !queue_en_n;

   // execution hand-off
   always_ff @(posedge CLK) begin
      if (RST) begin
         EXEC_START  <= 1'b0;
         EXEC_OPCODE <= 5'h00;
         EXEC_PARAMS <= '0;
      end else begin
         EXEC_START <= (phase == PH_PARAM && WR_STB && last_param);
         if (phase == PH_PARAM && WR_STB && last_param) begin
            EXEC_OPCODE                      <= opcode;
            EXEC_PARAMS.drive                <= param_view[0][1:0];
            EXEC_PARAMS.cylinder             <= (opcode == OP_FORMAT) ? 8'h00 : param_view[1];
            EXEC_PARAMS.fill_pattern         <= (opcode == OP_FORMAT) ? WR_DATA : 8'h00;
            EXEC_PARAMS.size_code            <= param_view[(opcode == OP_FORMAT) ? 1 : 4][2:0];
            EXEC_PARAMS.short_sector_length  <= WR_DATA;
            EXEC_PARAMS.step_inward          <= param_view[0][DIR_BIT];
            EXEC_PARAMS.verify_by_count_flag <= (opcode == OP_VERIFY) &&
                                                param_view[0][EC_BIT+7];
            EXEC_PARAMS.seek_first           <= IMPLIED_SEEK_ENABLE &&
               (opcode == OP_READ || opcode == OP_WRITE || opcode == OP_VERIFY);
         end
      end
   end

   // selected drive decoded to one-hot
   always_comb begin
      DRIVE_SELECT_ONEHOT = 4'h0;
      DRIVE_SELECT_ONEHOT[EXEC_PARAMS.drive] = 1'b1;
   end

   fcp_sector_len u_len (
      .size_code    (EXEC_PARAMS.size_code),
      .short_len    (EXEC_PARAMS.short_sector_length),
      .by_count     (EXEC_PARAMS.verify_by_count_flag),
      .phys_bytes   (PHYS_BYTES),
      .host_bytes   (HOST_BYTES),
      .zero_fill    (ZERO_FILL),
      .sector_count (SECTORS_PER_TRACK)
   );

   // checks
   sequence s_exec_done;
      phase == PH_EXEC && EXEC_DONE;
   endsequence
   chk_result_irq: assert property (@(posedge CLK) disable iff (RST)
      s_exec_done |=> FLOPPY_IRQ && TRANSFER_TOWARD_HOST)
      else $error("no irq at result entry");
   chk_result_bits: assert property (@(posedge CLK) disable iff (RST)
      phase == PH_RESULT && !wr_seen |-> HOST_REQUEST_READY && TRANSFER_TOWARD_HOST)
      else $error("result status bits wrong");
   chk_last_read: assert property (@(posedge CLK) disable iff (RST)
      phase == PH_RESULT && RD_STB && last_result
      |=> HOST_REQUEST_READY && !TRANSFER_TOWARD_HOST && !CONTROLLER_BUSY)
      else $error("not ready after last result");
   chk_hold_result: assert property (@(posedge CLK) disable iff (RST)
      phase == PH_RESULT && !(RD_STB && last_result) |=> phase == PH_RESULT)
      else $error("result phase left early");
   chk_invalid_irq: assert property (@(posedge CLK) disable iff (RST)
      WR_STB && phase == PH_CMD && !first_valid |=> FLOPPY_IRQ && invalid_pending)
      else $error("invalid command not flagged");
   chk_ready_drop: assert property (@(posedge CLK) disable iff (RST)
      WR_STB |=> !HOST_REQUEST_READY)
      else $error("ready not dropped after write");
   chk_busy_set: assert property (@(posedge CLK) disable iff (RST)
      WR_STB && phase == PH_CMD && first_valid |=> CONTROLLER_BUSY)
      else $error("busy not set");
   chk_queue_en: assert property (@(posedge CLK) disable iff (RST)
      $past(RST) |-> !QUEUE_ENABLE)
      else $error("queue enabled at reset");
   chk_queue_cfg: assert property (@(posedge CLK) disable iff (RST)
      phase == PH_PARAM && WR_STB && last_param && opcode == OP_CONFIGURE
      |=> QUEUE_ENABLE == !$past(WR_DATA[CFG_QUEUE_EN_N_BIT]))
      else $error("queue enable not taken from configure");
endmodule : fcp_core
`default_nettype wire

// ### hw/fcp_pkg.sv
// package of constants and carriers for the floppy command/result interpreter
package fcp_pkg;
   // phase encodings, one-hot
   localparam int PH_W = 4;
   // command opcode values (low five bits of first byte)
   localparam logic [4:0] OP_READ        = 5'h06;
   localparam logic [4:0] OP_WRITE       = 5'h05;
   localparam logic [4:0] OP_FORMAT      = 5'h0D;
   localparam logic [4:0] OP_SEEK        = 5'h0F;
   localparam logic [4:0] OP_SENSE_INT   = 5'h08;
   localparam logic [4:0] OP_CONFIGURE   = 5'h13;
   localparam logic [4:0] OP_PERP        = 5'h12;
   localparam logic [4:0] OP_VERIFY      = 5'h16;
   // status byte 0 values for invalid and normal command
   localparam logic [7:0] ST0_INVALID    = 8'h80;
   localparam logic [7:0] ST0_NORMAL     = 8'h20;
   // sizes
   localparam logic [7:0] SHORT_LEN_DFLT = 8'hFF;
   localparam int         NOMINAL_SECTOR = 128;
   localparam int         MAX_PARAMS     = 8;
   localparam int         MAX_RESULTS    = 7;
   // configure byte field positions
   localparam int CFG_IMPLIED_SEEK_BIT   = 6;
   localparam int CFG_QUEUE_EN_N_BIT     = 5;
   // parameter byte positions, then configure queue-disable reset value
   localparam int DIR_BIT                = 6;
   localparam int EC_BIT                 = 0;
   localparam logic CFG_QUEUE_EN_N_RST   = 1'b1;

   // decoded parameters handed to the execution side
   typedef struct packed {
      logic [1:0] drive;
      logic [7:0] cylinder;
      logic [7:0] fill_pattern;
      logic [2:0] size_code;
      logic [7:0] short_sector_length;
      logic       step_inward;
      logic       verify_by_count_flag;
      logic       seek_first;
   } fcp_params_t;
endpackage : fcp_pkg

// ### hw/fcp_sector_len.sv
// transfer length calculator for short and full sectors
`timescale 1ns/1ps
`default_nettype none
module fcp_sector_len (
   // parameter inputs
   input  wire logic [2:0]  size_code,
   input  wire logic [7:0]  short_len,
   input  wire logic        by_count,
   // lengths
   output logic      [14:0] phys_bytes,
   output logic      [14:0] host_bytes,
   output logic      [14:0] zero_fill,
   output logic      [7:0]  sector_count
);
   import fcp_pkg::*;
   // physical sector always full size so crc spans it all
   assign phys_bytes = 15'(NOMINAL_SECTOR) << size_code;
   // short length applies only when code is zero and not counting
   always_comb begin
      if (size_code == 3'h0 && !by_count) begin
         host_bytes = (short_len < 8'(NOMINAL_SECTOR)) ? {7'h00, short_len}
                                                       : phys_bytes;
      end else begin
         host_bytes = phys_bytes;
      end
      zero_fill    = phys_bytes - host_bytes;
      sector_count = by_count ? short_len : 8'h00;
   end
endmodule : fcp_sector_len
`default_nettype wire

// ### testbench/fcp_exec_model.sv
// execution engine model that answers each started command
`timescale 1ns/1ps
`default_nettype none
module fcp_exec_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // start from the interpreter and chosen latency
   input  wire logic       start,
   input  wire logic [7:0] delay,
   // completion back to the interpreter
   output logic            done,
   output logic [7:0]      st0
);
   int cnt = -1;
   initial st0 = 8'hA5;
   // status is only meaningful with done, so it toggles otherwise
   always @(posedge clk) begin
      done <= 1'b0;
      st0  <= ~st0;
      if (rst) cnt = -1;
      else if (start === 1'b1) cnt = delay;
      else if (cnt > 0) cnt = cnt - 1;
      else if (cnt == 0) begin
         done <= 1'b1;
         st0  <= 8'h20;
         cnt = -1;
      end
   end
endmodule : fcp_exec_model
`default_nettype wire

// ### testbench/floppy_result_and_command_params_bench.sv
// self-checking bench for the floppy command/result interpreter
`timescale 1ns/1ps
`default_nettype none
module floppy_result_and_command_params_bench;
   import fcp_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic [7:0]  wr_data = 8'h00;
   logic [7:0]  dly = 8'h00;
   logic [7:0]  rd_data, st0;
   logic        rdy, dir, busy, irq, x_start, x_done, qen, iseek;
   logic [4:0]  x_op, got_op;
   fcp_params_t x_par;
   logic [3:0]  onehot, perp;
   logic [14:0] phys, host, zfill;
   logic [7:0]  spt;
   logic [7:0]  p [8];
   int          num_errors = 0;
   int          checks_done = 0;

   always #2.5 clk = ~clk;

   fcp_core fcp_core_i (.CLK(clk), .RST(rst), .WR_STB(wr_stb), .WR_DATA(wr_data),
      .RD_STB(rd_stb), .RD_DATA(rd_data), .HOST_REQUEST_READY(rdy),
      .TRANSFER_TOWARD_HOST(dir), .CONTROLLER_BUSY(busy), .FLOPPY_IRQ(irq),
      .EXEC_START(x_start), .EXEC_OPCODE(x_op), .EXEC_PARAMS(x_par), .EXEC_DONE(x_done),
      .EXEC_ST0(st0), .DRIVE_SELECT_ONEHOT(onehot), .PERPENDICULAR_DRIVE_FLAGS(perp),
      .QUEUE_ENABLE(qen), .IMPLIED_SEEK_ENABLE(iseek), .PHYS_BYTES(phys),
      .HOST_BYTES(host), .ZERO_FILL(zfill), .SECTORS_PER_TRACK(spt));
   fcp_exec_model fcp_exec_model_i (.clk(clk), .rst(rst), .start(x_start), .delay(dly),
      .done(x_done), .st0(st0));

   // remember the opcode each started command carried
   always @(posedge clk) if (x_start === 1'b1) got_op <= x_op;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic results();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   // one host byte, only once ready shows and direction points inward
   task automatic wr(input logic [7:0] b);
      for (int i = 0; i < 100 && !(rdy === 1'b1 && dir === 1'b0); i++) step();
      wr_data = b;
      wr_stb  = 1'b1;
      step();
      wr_stb  = 1'b0;
      chk(rdy, 1'b0);
   endtask : wr

   // opcode and n parameters, then result bytes compared in order
   task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] exp [$],
                      input logic lenient);
      int i;
      got_op = 5'h1F;
      dly = 8'($urandom_range(0, 20));
      wr(op);
      chk(busy, 1'b1);
      for (i = 0; i < n; i++) wr(p[i]);
      // wait until result bytes are offered: ready and direction both one
      for (i = 0; i < 300 && !(rdy === 1'b1 && dir === 1'b1); i++) step();
      foreach (exp[k]) begin
         chk({irq | k > 0 | got_op === 5'h1F, rdy, dir, busy}, 4'hF);
         chk(rd_data, exp[k]);
         rd_stb = 1'b1;
         step();
         rd_stb = 1'b0;
         step();
      end
      // commands without defined results here are simply drained
      for (i = 0; i < 9 && lenient && dir === 1'b1; i++) begin
         rd_stb = 1'b1;
         step();
         rd_stb = 1'b0;
         step();
      end
      chk({rdy, dir, busy}, 3'b100);
   endtask : cmd

   initial begin
      logic [7:0] q [$];
      logic [7:0] c;
      int n;
      void'($urandom(91));
      repeat (4) @(posedge clk);
      #1;
      chk({rdy, dir, busy, irq, qen}, 5'b10000);
      rst = 1'b0;
      // an opcode outside the set is refused and flagged
      wr(8'h00);
      for (int i = 0; i < 20 && irq !== 1'b1; i++) step();
      chk({irq, busy, dir}, 3'b100);
      q = '{ST0_INVALID};
      cmd({3'b000, OP_SENSE_INT}, 0, q, 1'b0);
      for (int i = 0; i < 4; i++) begin
         // both slots carry the byte, bits 6 and 5 walk all pairs
         c = {1'b0, i[1], i[0], 5'h00};
         p[0] = c;
         p[1] = c;
         q = {};
         cmd({3'b000, OP_CONFIGURE}, 2, q, 1'b1);
         chk({iseek, qen}, {i[1], ~i[0]});
         // transfer on drive i with size code i, cylinder at both ends
         p[0] = 8'(i);
         p[1] = (i == 0) ? 8'h00 : (i == 3) ? 8'hFF : 8'($urandom);
         p[2] = 8'h00;
         p[3] = 8'h01;
         p[4] = 8'(i);
         p[5] = 8'h09;
         p[6] = 8'h1B;
         p[7] = i ? 8'hFF : 8'($urandom_range(1, 127));
         q = '{ST0_NORMAL, p[1]};
         cmd({3'b000, i[0] ? OP_WRITE : OP_READ}, 8, q, 1'b0);
         n = 128 << i;
         chk(got_op, i[0] ? OP_WRITE : OP_READ);
         chk({x_par.drive, x_par.cylinder, x_par.size_code, x_par.seek_first},
             {i[1:0], p[1], 3'(i), i[1]});
         chk(onehot, 4'h1 << i);
         chk(phys, 16'(n));
         chk(host, i ? 16'(n) : 16'(p[7]));
         chk(zfill, i ? 16'h0000 : 16'(n - p[7]));
         // relative seek with the direction bit following i
         p[0] = {1'b0, i[0], 4'h0, i[1:0]};
         p[1] = 8'($urandom);
         q = '{ST0_NORMAL, p[1]};
         cmd({3'b000, OP_SEEK}, 2, q, 1'b0);
         chk({x_par.step_inward, x_par.cylinder}, {i[0], p[1]});
      end
      // format pattern handed on for every data field
      p[0] = 8'h01;
      p[1] = 8'h02;
      p[2] = 8'h09;
      p[3] = 8'h54;
      p[4] = 8'($urandom);
      q = '{ST0_NORMAL, p[1]};
      cmd({3'b000, OP_FORMAT}, 5, q, 1'b0);
      chk(x_par.fill_pattern, p[4]);
      // perpendicular flags, one per drive
      p[0] = {4'h0, 4'($urandom)};
      q = {};
      cmd({3'b000, OP_PERP}, 1, q, 1'b1);
      chk(perp, p[0][3:0]);
      // verify with count flag turns short length into sectors per track
      p[0] = 8'h82;
      p[4] = 8'h01;
      p[7] = 8'($urandom_range(1, 36));
      q = '{ST0_NORMAL, p[1]};
      cmd({3'b000, OP_VERIFY}, 8, q, 1'b0);
      chk({x_par.verify_by_count_flag, spt}, {1'b1, p[7]});
      results();
   end

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      num_errors++;
      results();
   end
endmodule : floppy_result_and_command_params_bench
`default_nettype wire
